// >>> rtl/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
`define SSP_OFF_CTRL1 12'h000
`define SSP_OFF_CTRL2 12'h004
`define SSP_OFF_STAT 12'h008
`define SSP_OFF_BUF 12'h00C
`define SSP_OFF_T2 12'h010
`define SSP_B_EN 5
`define SSP_B_CKP 4
`define SSP_B_SMP 7
`define SSP_B_CKE 6
`define SSP_B_BF 0
`define SSP_B_ACKDV 5
`define SSP_B_ACKGO 4
`define SSP_B_RXGO 3
`define SSP_B_STOPGO 2
`define SSP_B_RSGO 1
`define SSP_B_STGO 0
`define SSP_M_DIV4 4'h0
`define SSP_M_DIV16 4'h1
`define SSP_M_DIV64 4'h2
`define SSP_M_TIMER_TWO 4'h3
`define SSP_M_SLV_SS 4'h4
`define SSP_M_SLV_NOSS 4'h5
`define SSP_M_I2C_MST 4'h8
`define SSP_HALF4 8'h01
`define SSP_HALF16 8'h07
`define SSP_HALF64 8'h1F
`define SSP_BITS 4'h8
`endif

// >>> rtl/ssp_port.v
`timescale 1ns/100ps
`include "ssp_defines.vh"
module ssp_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer_two_tick,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  input wire ss_n,
  input wire sda_in,
  output reg sda_oe,
  input wire scl_in,
  output reg scl_oe
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_RSTART = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_RX = 3'h4;
  localparam ST_ACK = 3'h5;
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [1:0] stat_q;
  reg [7:0] buf_q;
  reg bf_q;
  reg [7:0] t2_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg busy_q;
  reg [7:0] div_q;
  reg sck_q;
  reg samp_q;
  reg [2:0] ist_q;
  reg [1:0] iph_q;
  reg [7:0] idiv_q;
  reg [3:0] icnt_q;
  reg [7:0] ish_q;
  reg irx_done_q;
  wire [2:0] pins;
  wire sck_s;
  wire ss_s;
  wire sdi_s;
  reg sck_p_q;
  wire [3:0] mode = ctrl1_q[3:0];
  wire en = ctrl1_q[`SSP_B_EN];
  wire clock_idle_polarity = ctrl1_q[`SSP_B_CKP];
  wire cke = stat_q[0];
  wire smp = stat_q[1];
  wire master = (mode == `SSP_M_DIV4) || (mode == `SSP_M_DIV16) || (mode == `SSP_M_DIV64)
    || (mode == `SSP_M_TIMER_TWO);
  wire slave = (mode == `SSP_M_SLV_SS) || (mode == `SSP_M_SLV_NOSS);
  wire ss_use = (mode == `SSP_M_SLV_SS);
  wire i2cm = (mode == `SSP_M_I2C_MST);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire buf_wr = wr && (paddr == `SSP_OFF_BUF);
  ////////////////////////////////////////////////////////////////////////////
  function [7:0] half_of;
    input [3:0] m;
    begin
      case (m)
        `SSP_M_DIV4: half_of = `SSP_HALF4;
        `SSP_M_DIV16: half_of = `SSP_HALF16;
        default: half_of = `SSP_HALF64;
      endcase
    end
  endfunction
  ssp_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({sck_in, ss_n, sdi}),
    .q(pins)
  );
  assign sck_s = pins[2];
  assign ss_s = pins[1];
  assign sdi_s = pins[0];
  ////////////////////////////////////////////////////////////////////////////
  // Register access; a CTRL2 write is taken only while the I2C engine is idle, and then wins over a hardware clear of the go bits.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_q <= 8'h00;
      stat_q <= 2'h0;
      t2_q <= 8'h00;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (wr && !pready)
      begin
        case (paddr)
          `SSP_OFF_CTRL1: ctrl1_q <= pwdata[7:0];
          `SSP_OFF_STAT: stat_q <= pwdata[7:6];
          `SSP_OFF_T2: t2_q <= pwdata[7:0];
          `SSP_OFF_CTRL2, `SSP_OFF_BUF: ;
          default: pslverr <= 1'b1;
        endcase
      end
      if (rd && !pready)
      begin
        case (paddr)
          `SSP_OFF_CTRL1: prdata <= {24'h000000, ctrl1_q};
          `SSP_OFF_CTRL2: prdata <= {24'h000000, ctrl2_q};
          `SSP_OFF_STAT: prdata <= {24'h000000, stat_q, 5'h00, bf_q};
          `SSP_OFF_BUF: prdata <= {24'h000000, buf_q};
          `SSP_OFF_T2: prdata <= {24'h000000, t2_q};
          default:
          begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // SPI engine: master clock generation, slave edge following, MSb first.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      samp_q <= 1'b0;
      buf_q <= 8'h00;
      bf_q <= 1'b0;
      sck_p_q <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end
    else
    begin
      sck_p_q <= sck_s;
      if (rd && !pready && paddr == `SSP_OFF_BUF)
        bf_q <= 1'b0;
      sck_oe <= en && master;
      sdo_oe <= en && (master || (slave && !(ss_use && ss_s)));
      if (!en || !(master || slave) || (ss_use && ss_s))
      begin
        busy_q <= 1'b0;
        cnt_q <= 4'h0;
        sck_q <= 1'b0;
        sck_out <= clock_idle_polarity;
        if (buf_wr && !pready)
          sh_q <= pwdata[7:0];
        if (irx_done_q)
        begin
          buf_q <= ish_q;
          bf_q <= 1'b1;
        end
      end
      else if (master)
      begin
        if (!busy_q)
        begin
          sck_out <= clock_idle_polarity;
          sck_q <= 1'b0;
          if (buf_wr && !pready)
          begin
            sh_q <= pwdata[7:0];
            sdo <= pwdata[7];
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
            div_q <= 8'h00;
          end
        end
        else if ((mode == `SSP_M_TIMER_TWO) ? timer_two_tick : (div_q == half_of(mode)))
        begin
          div_q <= 8'h00;
          sck_q <= !sck_q;
          sck_out <= clock_idle_polarity ^ !sck_q;
          if (!sck_q)
          begin
            if (cke)
              samp_q <= sdi_s;
            else
              sdo <= sh_q[7];
          end
          if (sck_q)
          begin
            sh_q <= {sh_q[6:0], (cke && !smp) ? samp_q : sdi_s};
            if (cke)
              sdo <= sh_q[6];
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `SSP_BITS - 4'h1)
            begin
              busy_q <= 1'b0;
              buf_q <= {sh_q[6:0], (cke && !smp) ? samp_q : sdi_s};
              bf_q <= 1'b1;
            end
          end
        end
        else if (mode != `SSP_M_TIMER_TWO)
          div_q <= div_q + 8'h01;
      end
      else
      begin
        if (buf_wr && !pready && cnt_q == 4'h0)
        begin
          sh_q <= pwdata[7:0];
          sdo <= pwdata[7];
        end
        if (sck_s != sck_p_q)
        begin
          if ((sck_s ^ clock_idle_polarity) != cke)
            samp_q <= sdi_s;
          else
          begin
            sh_q <= {sh_q[6:0], samp_q};
            sdo <= sh_q[6];
            cnt_q <= (cnt_q == `SSP_BITS - 4'h1) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == `SSP_BITS - 4'h1)
            begin
              buf_q <= {sh_q[6:0], samp_q};
              bf_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // I2C master sequences driven by the go bits, each cleared when done.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl2_q <= 8'h00;
      ist_q <= ST_IDLE;
      iph_q <= 2'h0;
      idiv_q <= 8'h00;
      icnt_q <= 4'h0;
      ish_q <= 8'h00;
      irx_done_q <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else
    begin
      irx_done_q <= 1'b0;
      if (wr && !pready && paddr == `SSP_OFF_CTRL2 && ist_q == ST_IDLE)
        ctrl2_q <= pwdata[7:0];
      else
      begin
        idiv_q <= (idiv_q == `SSP_HALF16) ? 8'h00 : idiv_q + 8'h01;
        if (idiv_q == `SSP_HALF16)
        begin
          iph_q <= iph_q + 2'h1;
          case (ist_q)
            ST_IDLE:
            begin
              iph_q <= 2'h0;
              if (i2cm && en && ctrl2_q[`SSP_B_STGO]) ist_q <= ST_START;
              else if (i2cm && en && ctrl2_q[`SSP_B_RSGO]) ist_q <= ST_RSTART;
              else if (i2cm && en && ctrl2_q[`SSP_B_STOPGO]) ist_q <= ST_STOP;
              else if (i2cm && en && ctrl2_q[`SSP_B_RXGO]) ist_q <= ST_RX;
              else if (i2cm && en && ctrl2_q[`SSP_B_ACKGO]) ist_q <= ST_ACK;
              else ctrl2_q[4:0] <= 5'h00;
              icnt_q <= 4'h0;
            end
            ST_START:
            begin
              sda_oe <= (iph_q != 2'h0);
              scl_oe <= (iph_q == 2'h3);
              if (iph_q == 2'h3)
              begin
                ctrl2_q[`SSP_B_STGO] <= 1'b0;
                ist_q <= ST_IDLE;
              end
            end
            ST_RSTART:
            begin
              sda_oe <= (iph_q == 2'h2) || (iph_q == 2'h3);
              scl_oe <= (iph_q == 2'h0) || (iph_q == 2'h3);
              if (iph_q == 2'h3)
              begin
                ctrl2_q[`SSP_B_RSGO] <= 1'b0;
                ist_q <= ST_IDLE;
              end
            end
            ST_STOP:
            begin
              sda_oe <= (iph_q != 2'h3);
              scl_oe <= (iph_q == 2'h0);
              if (iph_q == 2'h3)
              begin
                ctrl2_q[`SSP_B_STOPGO] <= 1'b0;
                ist_q <= ST_IDLE;
              end
            end
            ST_RX:
            begin
              sda_oe <= 1'b0;
              scl_oe <= (iph_q == 2'h0) || (iph_q == 2'h3);
              if (iph_q == 2'h2)
                ish_q <= {ish_q[6:0], sda_in};
              if (iph_q == 2'h3)
              begin
                icnt_q <= icnt_q + 4'h1;
                if (icnt_q == `SSP_BITS - 4'h1)
                begin
                  irx_done_q <= 1'b1;
                  ctrl2_q[`SSP_B_RXGO] <= 1'b0;
                  ist_q <= ST_IDLE;
                end
              end
            end
            ST_ACK:
            begin
              sda_oe <= !ctrl2_q[`SSP_B_ACKDV];
              scl_oe <= (iph_q == 2'h0) || (iph_q == 2'h3);
              if (iph_q == 2'h3)
              begin
                ctrl2_q[`SSP_B_ACKGO] <= 1'b0;
                ist_q <= ST_IDLE;
              end
            end
            default: ist_q <= ST_IDLE;
          endcase
        end
      end
    end
  end
endmodule // ssp_port

// >>> rtl/ssp_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for the SPI pins that come from the far party.
module ssp_sync #(
  parameter W = 3
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // ssp_sync

// >>> testbench/ssp_peer.sv
`timescale 1ns/100ps
// SPI slave on the far side and the pulled-up I2C lines.
module ssp_peer (
  input wire sck,
  input wire sdo,
  input wire cpol,
  input wire ph,
  input wire sda_oe,
  input wire scl_oe,
  output wire sdi,
  output wire sda,
  output wire scl
);
  reg [8:0] tx_q;
  reg [7:0] rx_q;
  reg [3:0] cnt_q;
  reg busy_q;
  // Outside a frame the data line shows the inverse of the last bit.
  assign sdi = busy_q ? tx_q[8] : ~tx_q[8];
  // Both open-drain lines float high through pull-ups.
  assign sda = ~sda_oe;
  assign scl = ~scl_oe;
  initial
  begin
    busy_q = 1'b0;
    tx_q = 9'h000;
  end
  task load(input [7:0] b);
  begin
    tx_q = ph ? {1'b0, b} : {b, 1'b0};
    cnt_q = 4'h0;
    busy_q = 1'b1;
  end
  endtask
  always @(sck)
  begin
    if (busy_q && ((sck != cpol) ^ ph))
    begin
      rx_q = {rx_q[6:0], sdo};
      cnt_q = cnt_q + 4'h1;
      if (cnt_q == 4'h8)
        busy_q = 1'b0;
    end
    else if (busy_q)
      tx_q = {tx_q[7:0], 1'b0};
  end
endmodule // ssp_peer

// >>> testbench/ssp_port_asserts.sv
`timescale 1ns/100ps
// Checks the port pins against the control words written to it.
module ssp_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire sck_out,
  input wire sck_oe,
  input wire sdo_oe,
  input wire ss_n
);
  reg [3:0] mode_q;
  reg en_q;
  reg ckp_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= 4'h0;
      en_q <= 1'b0;
      ckp_q <= 1'b0;
    end
    else if (psel && penable && pready && pwrite && paddr == 12'h000)
    begin
      mode_q <= pwdata[3:0];
      en_q <= pwdata[5];
      ckp_q <= pwdata[4];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_master_idle: assert property (s_ctrl_wr ##0 (pwdata[5] && pwdata[3:2] == 2'b00) |->
    ##3 (sck_oe && sck_out == $past(pwdata[4], 3)))
    else $error("master clock not driven at idle level");
  a_slave_clk: assert property (s_ctrl_wr ##0 (pwdata[3:1] == 3'b010) |-> ##3 !sck_oe)
    else $error("slave drives the serial clock");
  a_div4_rate: assert property ($rose(sck_out) && en_q && mode_q == 4'h0 && !ckp_q |->
    sck_out [*2] ##1 !sck_out)
    else $error("divide by four clock wrong");
  a_ss_release: assert property ((ss_n && en_q && mode_q == 4'h4) [*4] |-> !sdo_oe)
    else $error("data out driven while deselected");
endmodule // ssp_chk
bind ssp_port ssp_chk ssp_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .ss_n(ss_n));

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg pclk, presetn, psel, penable, pwrite, ss_n, cpol, ph, err, ack_seen;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] rate;
  reg [7:0] txb;
  reg [2:0] tcnt;
  wire [31:0] prdata;
  wire pready, pslverr, sdo, sdo_oe, sck_out, sck_oe, sda_oe, scl_oe, sdi, sda, scl;
  wire tick = (tcnt == 3'h7);
  integer n_mismatch, checks, i, n_start, n_stop;
  ssp_port ssp_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_two_tick(tick), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .sck_in(cpol), .sck_out(sck_out), .sck_oe(sck_oe), .ss_n(ss_n), .sda_in(sda),
    .sda_oe(sda_oe), .scl_in(scl), .scl_oe(scl_oe));
  ssp_peer ssp_peer_i (.sck(sck_out), .sdo(sdo), .cpol(cpol), .ph(ph), .sda_oe(sda_oe),
    .scl_oe(scl_oe), .sdi(sdi), .sda(sda), .scl(scl));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) tcnt <= tcnt + 3'h1;
  always @(negedge sda) if (scl === 1'b1) n_start = n_start + 1;
  always @(posedge sda) if (scl === 1'b1) n_stop = n_stop + 1;
  always @(posedge scl) ack_seen = sda;
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task poll(input [11:0] a, input [31:0] m, input [31:0] v);
  begin
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== v)
      apb(1'b0, a, 32'h0);
    chk(rd & m, v);
  end
  endtask
  task i2c_go(input [31:0] d);
  begin
    apb(1'b1, 12'h004, d);
    poll(12'h004, 32'h1F, 32'h0);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cpol, ph} = 0;
    ss_n = 1'b1;
    tcnt = 3'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    n_start = 0;
    n_stop = 0;
    @(posedge pclk);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 5; i = i + 1)
    begin
      cpol <= i[1];
      ph <= ~(i[0] | i[2]);
      rate = (i == 4) ? 4'h0 : (i == 3) ? 4'h1 : i[3:0] + 4'h1;
      txb = 8'hA5 ^ i[7:0];
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, {24'h0, 1'b0, i[0] | i[2], 6'h0});
      apb(1'b1, 12'h000, {26'h0, 1'b1, i[1], rate});
      repeat (4) @(posedge pclk);
      chk({30'h0, sck_oe, sck_out}, {30'h0, 1'b1, cpol});
      ssp_peer_i.load(8'h3C + i[7:0]);
      apb(1'b1, 12'h00C, {24'h0, txb});
      poll(12'h008, 32'h1, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      if (i < 4) chk(rd, {24'h0, 8'h3C + i[7:0]});
      chk({24'h0, ssp_peer_i.rx_q}, {24'h0, txb});
    end
    cpol <= 1'b0;
    for (i = 0; i < 3; i = i + 1)
    begin
      ss_n <= (i != 1);
      apb(1'b1, 12'h000, (i == 2) ? 32'h25 : 32'h24);
      repeat (6) @(posedge pclk);
      chk({30'h0, sck_oe, sdo_oe}, {30'h0, 1'b0, i != 0});
    end
    apb(1'b1, 12'h000, 32'h28);
    i2c_go(32'h01);
    chk(n_start, 1);
    i2c_go(32'h08);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'hFF);
    i2c_go(32'h10);
    chk({31'h0, ack_seen}, 32'h0);
    i2c_go(32'h02);
    chk(n_start, 2);
    i2c_go(32'h08);
    i2c_go(32'h30);
    chk({31'h0, ack_seen}, 32'h1);
    i2c_go(32'h04);
    chk(n_stop, 1);
    stop_test;
  end
endmodule // tb_top
